// ### src/lfwc_correlator.sv
// Purpose: Preamble and Manchester pattern correlator with wake output and timeout
// Assumes: Inputs synchronous to clock; rtc_tick marks one RTC period
// Notes: Envelope is sampled at the end of each half-bit interval
// What this block does
// - Correlation runs after frequency detection only when enabled, else wake follows detection directly.
// - If no preamble shows within 16 bits the block returns to listening and bumps the false count.
// - Pattern matching starts only after at least 4 bits of alternating preamble.
// - Bit length is the 5-bit code plus one RTC periods, from 4 at code 3 to 32 at code 31.
// - The expected pattern is 16 half bits held in two programmable bytes.
// - Manchester coding: low-high is symbol zero, high-low is symbol one.
// - The pattern is sent and compared most significant bit first.
// - A config bit picks single or double pattern, double needing two matches back to back.
// - A 2-bit field allows zero to three missed zero bits in the pattern.
// - A match within tolerance raises the wake output.
// - A failed detection ends quietly and increments the 8-bit false wake-up count.
// - The clear-wake command ends the wake state.
// - A 3-bit field ends the wake state after 50 ms per step, up to 350 ms.
// - Timeout counting starts at the rising edge of wake.
// - Wake rises one bit period after the last pattern bit.
module lfwc_correlator #(
    parameter int TOUT_STEP = lfwc_pkg::TOUT_STEP_CYC
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic rtc_tick,
    input wire logic freq_detect,
    input wire logic envelope,
    input wire logic clear_wake,
    input wire logic reg_wr,
    input wire logic [4:0] reg_idx,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_q,
    output logic [7:0] false_wakeup_count_q,
    output logic wake_q
);
    logic [7:0] general_config_reg_q;
    logic [7:0] detection_tolerance_reg_q;
    logic [7:0] wake_pattern_byte_a_q;
    logic [7:0] wake_pattern_byte_b_q;
    logic [7:0] bit_period_and_timeout_q;
    lfwc_pkg::lfwc_cfg_t cfg;
    lfwc_pkg::lfwc_state_t state_q;
    logic [5:0] bit_len;
    logic [4:0] half_len;
    logic [4:0] tick_cnt_q;
    logic half_edge;
    logic [7:0] half_cnt_q;
    logic [7:0] pre_run_q;
    logic prev_env_q;
    logic [15:0] shift_q;
    logic [4:0] pat_cnt_q;
    logic first_done_q;
    logic [1:0] gap_cnt_q;
    logic [31:0] tout_cnt_q;
    logic [31:0] tout_limit_q;
    logic [15:0] shifted;
    logic [15:0] expected;
    logic [4:0] missed;
    logic exact_ones;
    logic match;
    logic fail;
    logic pre_ok;
    logic full_pat;

    // Count ones in a vector; used for tolerance checks
    function automatic logic [4:0] count_ones(input logic [15:0] v);
        logic [4:0] n;
        n = 5'h00;
        for (int i = 0; i < 16; i++) begin
            n = n + {4'h0, v[i]};
        end
        return n;
    endfunction : count_ones

    // Clamp the code so a reserved low code never gives a one-tick half bit
    function automatic logic [5:0] bit_len_of(input logic [4:0] code);
        logic [5:0] n;
        n = {1'b0, code} + 6'h01;
        if (n < lfwc_pkg::BIT_LEN_MIN) begin
            n = lfwc_pkg::BIT_LEN_MIN;
        end
        return n;
    endfunction : bit_len_of

    assign cfg.corr_en = general_config_reg_q[lfwc_pkg::POS_CORR_EN];
    assign cfg.double_en = general_config_reg_q[lfwc_pkg::POS_DOUBLE];
    assign cfg.tol = detection_tolerance_reg_q[lfwc_pkg::POS_TOL_LO +: 2];
    assign cfg.bit_code = bit_period_and_timeout_q[4:0];
    assign cfg.tout_code = bit_period_and_timeout_q[lfwc_pkg::POS_TOUT_LO +: 3];

    // Bit length and half-bit length; an odd length drops its spare tick
    assign bit_len = bit_len_of(cfg.bit_code);
    assign half_len = bit_len[5:1];
    assign half_edge = rtc_tick && (tick_cnt_q == half_len - 5'h01);

    // Pattern compare, MSB first: oldest half bit sits in the top position
    assign shifted = {shift_q[14:0], envelope};
    assign expected = {wake_pattern_byte_a_q, wake_pattern_byte_b_q};
    assign missed = count_ones(expected & ~shifted);
    assign exact_ones = ((shifted & ~expected) == 16'h0000);
    // A missed zero shows as a lost carrier half; extra carrier never passes
    assign match = exact_ones && (missed <= {3'h0, cfg.tol});
    // Preamble completes only when the eighth half on this edge still alternates
    assign pre_ok = (envelope != prev_env_q) && (pre_run_q + 8'h01 >= lfwc_pkg::PRE_MIN_HALVES);
    assign full_pat = (pat_cnt_q + 5'h01 >= lfwc_pkg::PATTERN_HALVES);
    // Failure: no preamble in the wait window, frame overrun, or a second copy that does not match
    assign fail = half_edge && (((state_q == lfwc_pkg::ST_PREAMBLE) && (half_cnt_q + 8'h01 >= lfwc_pkg::PRE_WAIT_HALVES)
        && !pre_ok)
        || ((state_q == lfwc_pkg::ST_PATTERN) && !(match && full_pat)
        && ((half_cnt_q + 8'h01 >= lfwc_pkg::FRAME_MAX_HALVES) || (first_done_q && full_pat))));

    // Register port writes; the false count is read only
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            general_config_reg_q <= lfwc_pkg::RST_GENERAL_CONFIG;
            detection_tolerance_reg_q <= lfwc_pkg::RST_DETECT_TOL;
            wake_pattern_byte_a_q <= lfwc_pkg::RST_PATTERN_A;
            wake_pattern_byte_b_q <= lfwc_pkg::RST_PATTERN_B;
            bit_period_and_timeout_q <= lfwc_pkg::RST_BIT_TIMEOUT;
        end else if (reg_wr) begin
            case (reg_idx)
                lfwc_pkg::IDX_GENERAL_CONFIG: general_config_reg_q <= reg_wdata;
                lfwc_pkg::IDX_DETECT_TOL: detection_tolerance_reg_q <= reg_wdata;
                lfwc_pkg::IDX_PATTERN_A: wake_pattern_byte_a_q <= reg_wdata;
                lfwc_pkg::IDX_PATTERN_B: wake_pattern_byte_b_q <= reg_wdata;
                lfwc_pkg::IDX_BIT_TIMEOUT: bit_period_and_timeout_q <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Registered read mux; unmapped indices read zero
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_q <= 8'h00;
        end else begin
            case (reg_idx)
                lfwc_pkg::IDX_GENERAL_CONFIG: reg_rdata_q <= general_config_reg_q;
                lfwc_pkg::IDX_DETECT_TOL: reg_rdata_q <= detection_tolerance_reg_q;
                lfwc_pkg::IDX_PATTERN_A: reg_rdata_q <= wake_pattern_byte_a_q;
                lfwc_pkg::IDX_PATTERN_B: reg_rdata_q <= wake_pattern_byte_b_q;
                lfwc_pkg::IDX_BIT_TIMEOUT: reg_rdata_q <= bit_period_and_timeout_q;
                lfwc_pkg::IDX_FALSE_COUNT: reg_rdata_q <= false_wakeup_count_q;
                default: reg_rdata_q <= 8'h00;
            endcase
        end
    end

    // RTC tick counter within a half bit; restarts at each new frame
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tick_cnt_q <= 5'h00;
        end else if (state_q == lfwc_pkg::ST_IDLE || state_q == lfwc_pkg::ST_WAKE || half_edge) begin
            tick_cnt_q <= 5'h00;
        end else if (rtc_tick) begin
            tick_cnt_q <= tick_cnt_q + 5'h01;
        end
    end

    // False wake-up counter wraps at 255, like any 8-bit counter
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            false_wakeup_count_q <= 8'h00;
        end else if (fail) begin
            false_wakeup_count_q <= false_wakeup_count_q + 8'h01;
        end
    end

    // Correlation sequence from detection to wake
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= lfwc_pkg::ST_IDLE;
            half_cnt_q <= 8'h00;
            pre_run_q <= 8'h00;
            prev_env_q <= 1'b0;
            shift_q <= 16'h0000;
            pat_cnt_q <= 5'h00;
            first_done_q <= 1'b0;
            gap_cnt_q <= 2'h0;
        end else begin
            case (state_q)
                lfwc_pkg::ST_IDLE: begin
                    half_cnt_q <= 8'h00;
                    pre_run_q <= 8'h00;
                    prev_env_q <= 1'b0;
                    pat_cnt_q <= 5'h00;
                    first_done_q <= 1'b0;
                    gap_cnt_q <= 2'h0;
                    if (freq_detect) begin
                        state_q <= cfg.corr_en ? lfwc_pkg::ST_PREAMBLE : lfwc_pkg::ST_WAKE;
                    end
                end
                lfwc_pkg::ST_PREAMBLE: if (half_edge) begin
                    half_cnt_q <= half_cnt_q + 8'h01;
                    prev_env_q <= envelope;
                    // A run of alternating halves is the on/off preamble
                    pre_run_q <= (envelope != prev_env_q) ? pre_run_q + 8'h01 : 8'h00;
                    if (fail) begin
                        state_q <= lfwc_pkg::ST_IDLE;
                    end else if (pre_ok) begin
                        state_q <= lfwc_pkg::ST_PATTERN;
                        shift_q <= 16'h0000;
                    end
                end
                lfwc_pkg::ST_PATTERN: if (half_edge) begin
                    half_cnt_q <= half_cnt_q + 8'h01;
                    shift_q <= shifted;
                    pat_cnt_q <= (pat_cnt_q < lfwc_pkg::PATTERN_HALVES) ? pat_cnt_q + 5'h01 : pat_cnt_q;
                    if (match && (pat_cnt_q + 5'h01 >= lfwc_pkg::PATTERN_HALVES)) begin
                        if (cfg.double_en && !first_done_q) begin
                            first_done_q <= 1'b1;
                            pat_cnt_q <= 5'h00;
                        end else begin
                            state_q <= lfwc_pkg::ST_GAP;
                        end
                    end else if (fail) begin
                        // Overrun, or a second copy that did not follow directly
                        state_q <= lfwc_pkg::ST_IDLE;
                    end
                end
                lfwc_pkg::ST_GAP: if (half_edge) begin
                    gap_cnt_q <= gap_cnt_q + 2'h1;
                    if (gap_cnt_q + 2'h1 >= lfwc_pkg::GAP_HALVES) begin
                        state_q <= lfwc_pkg::ST_WAKE;
                    end
                end
                lfwc_pkg::ST_WAKE: begin
                    if (clear_wake) begin
                        state_q <= lfwc_pkg::ST_IDLE;
                    end else if (wake_q && tout_limit_q != 32'h0 && tout_cnt_q + 32'h1 >= tout_limit_q) begin
                        state_q <= lfwc_pkg::ST_IDLE;
                    end
                end
                default: state_q <= lfwc_pkg::ST_IDLE;
            endcase
        end
    end

    // Wake output follows the wake state one cycle later
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= (state_q == lfwc_pkg::ST_WAKE) && !clear_wake;
        end
    end

    // Timeout counter starts at the wake rising edge; code 0 disables it
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tout_cnt_q <= 32'h0;
            tout_limit_q <= 32'h0;
        end else if (!wake_q) begin
            tout_cnt_q <= 32'h0;
            tout_limit_q <= 32'(cfg.tout_code) * 32'(TOUT_STEP);
        end else begin
            tout_cnt_q <= tout_cnt_q + 32'h1;
        end
    end

    a_no_corr_wake: assert property (@(posedge clock) disable iff (!reset_n)
        (state_q == lfwc_pkg::ST_IDLE && freq_detect && !cfg.corr_en && !clear_wake) |=> ##1 wake_q)
        else $error("Wake missing without correlation");
    a_pre_window: assert property (@(posedge clock) disable iff (!reset_n)
        state_q == lfwc_pkg::ST_PREAMBLE |-> half_cnt_q < lfwc_pkg::PRE_WAIT_HALVES)
        else $error("Preamble wait overran");
    a_pre_min_run: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(state_q == lfwc_pkg::ST_PATTERN) |-> $past(pre_run_q) + 8'h01 >= lfwc_pkg::PRE_MIN_HALVES)
        else $error("Pattern started on short preamble");
    a_bit_len_range: assert property (@(posedge clock) disable iff (!reset_n)
        bit_len >= lfwc_pkg::BIT_LEN_MIN && bit_len <= lfwc_pkg::BIT_LEN_MAX)
        else $error("Bit length out of range");
    a_tol_match: assert property (@(posedge clock) disable iff (!reset_n)
        (state_q == lfwc_pkg::ST_PATTERN && half_edge && full_pat && missed > {3'h0, cfg.tol})
        |=> state_q != lfwc_pkg::ST_GAP)
        else $error("Match beyond tolerance");
    a_fail_count: assert property (@(posedge clock) disable iff (!reset_n)
        fail |=> false_wakeup_count_q == $past(false_wakeup_count_q) + 8'h01 && !wake_q)
        else $error("False count not bumped");
    a_clear_ends: assert property (@(posedge clock) disable iff (!reset_n)
        (wake_q && clear_wake) |=> !wake_q ##1 !wake_q)
        else $error("Clear did not end wake");
    a_gap_wake: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(state_q == lfwc_pkg::ST_WAKE) && $past(state_q == lfwc_pkg::ST_GAP) |-> ##1 wake_q)
        else $error("Wake late after pattern");
    a_tout_start: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(wake_q) |=> tout_cnt_q == 32'h1)
        else $error("Timeout not started at wake edge");
    a_tout_end: assert property (@(posedge clock) disable iff (!reset_n)
        (wake_q && tout_limit_q != 32'h0 && tout_cnt_q > tout_limit_q) |-> 1'b0)
        else $error("Wake outlived timeout");
    a_pre_alt: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(state_q == lfwc_pkg::ST_PATTERN) |-> $past(envelope) != $past(prev_env_q))
        else $error("Pattern started on a broken preamble");
    a_double_gap: assert property (@(posedge clock) disable iff (!reset_n)
        (state_q == lfwc_pkg::ST_GAP && cfg.double_en) |-> first_done_q)
        else $error("Double mode woke on one copy");
    c_wake_pattern: cover property (@(posedge clock) disable iff (!reset_n)
        state_q == lfwc_pkg::ST_GAP ##[1:200] wake_q);
    c_double_first: cover property (@(posedge clock) disable iff (!reset_n) $rose(first_done_q));
    c_false_wake: cover property (@(posedge clock) disable iff (!reset_n) fail);
    c_timeout: cover property (@(posedge clock) disable iff (!reset_n) wake_q && tout_limit_q != 32'h0 ##1 !wake_q);
    c_copy_fail: cover property (@(posedge clock) disable iff (!reset_n) fail && first_done_q);
endmodule : lfwc_correlator

// ### src/lfwc_pkg.sv
// Purpose: Constants and types for the LF wake-up pattern correlator
// Assumes: 50 MHz system clock, RTC period marked by a one-cycle tick
// Notes: Register indices follow the device register numbering
package lfwc_pkg;
    // Register indices on the register port
    localparam logic [4:0] IDX_GENERAL_CONFIG = 5'h01;
    localparam logic [4:0] IDX_DETECT_TOL = 5'h02;
    localparam logic [4:0] IDX_PATTERN_A = 5'h05;
    localparam logic [4:0] IDX_PATTERN_B = 5'h06;
    localparam logic [4:0] IDX_BIT_TIMEOUT = 5'h07;
    localparam logic [4:0] IDX_FALSE_COUNT = 5'h0d;
    // Field positions
    localparam int POS_CORR_EN = 1;
    localparam int POS_DOUBLE = 2;
    localparam int POS_TOL_LO = 5;
    localparam int POS_TOUT_LO = 5;
    // Reset values
    localparam logic [7:0] RST_GENERAL_CONFIG = 8'h00;
    localparam logic [7:0] RST_DETECT_TOL = 8'h00;
    localparam logic [7:0] RST_PATTERN_A = 8'h96;
    localparam logic [7:0] RST_PATTERN_B = 8'h69;
    localparam logic [7:0] RST_BIT_TIMEOUT = 8'h0b;
    // Bit length limits in RTC periods, correlation windows in half bits
    localparam logic [5:0] BIT_LEN_MIN = 6'h04;
    localparam logic [5:0] BIT_LEN_MAX = 6'h20;
    localparam logic [7:0] PRE_WAIT_HALVES = 8'h20;  // 16 bits
    localparam logic [7:0] PRE_MIN_HALVES = 8'h08;   // 4 bits
    localparam logic [7:0] FRAME_MAX_HALVES = 8'h50; // 40 bits
    localparam logic [4:0] PATTERN_HALVES = 5'h10;
    localparam logic [1:0] GAP_HALVES = 2'h2;        // One bit
    // Timeout step
    localparam int CLK_HZ = 50_000_000;
    localparam int TOUT_STEP_MS = 50;
    localparam int TOUT_STEP_CYC = CLK_HZ / 1000 * TOUT_STEP_MS;

    typedef enum {
        ST_IDLE,
        ST_PREAMBLE,
        ST_PATTERN,
        ST_GAP,
        ST_WAKE
    } lfwc_state_t;

    typedef struct packed {
        logic corr_en;
        logic double_en;
        logic [1:0] tol;
        logic [4:0] bit_code;
        logic [2:0] tout_code;
    } lfwc_cfg_t;
endpackage : lfwc_pkg

// ### testbench/lfwc_tx_model.sv
// Purpose: Remote LF transmitter model driving carrier detect and the envelope
// Assumes: The receiver counts RTC ticks sampled on rising clock edges
// Notes: Levels change only on the edge where the receiver samples them
module lfwc_tx_model (
    input wire logic clock,
    input wire logic rtc_tick,
    output logic freq_detect,
    output logic envelope
);
    timeunit 1ns;
    timeprecision 1ns;

    // Quiet air until a burst is requested
    initial begin
        freq_detect = 1'b0;
        envelope = 1'b0;
    end

    // Waits n sampled RTC ticks, the same count the receiver keeps
    task automatic wait_ticks(input int n);
        for (int i = 0; i < n; i++) begin
            do @(posedge clock); while (rtc_tick !== 1'b1);
        end
    endtask : wait_ticks

    // Burst start right after a tick edge, so detect never meets a tick
    task automatic detect(output time t);
        wait_ticks(1);
        freq_detect <= 1'b1;
        @(posedge clock);
        freq_detect <= 1'b0;
        t = $time;
    endtask : detect

    // One envelope level per half bit, first half taken from the top bit
    task automatic send(input logic [47:0] b, input int n, input int half, input logic tail, output time t);
        detect(t);
        envelope <= b[n-1];
        for (int i = n - 2; i >= -1; i--) begin
            wait_ticks(half);
            envelope <= (i >= 0) ? b[i] : tail;
        end
        t = $time;
    endtask : send
endmodule : lfwc_tx_model

// ### testbench/lfwc_correlator_bench.sv
// Purpose: Self-checking bench for the LF wake-up pattern correlator
// Assumes: RTC tick every TP clocks, timeout step shortened to TSTEP clocks
// Notes: Drivers note expected events, a watcher compares them in order
module lfwc_correlator_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TP = 4;
    localparam int TSTEP = 20;
    typedef struct packed {
        logic [1:0] kind;
        logic [63:0] t;
        logic [7:0] v;
    } lfwc_note_t;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic rtc_tick = 1'b0;
    logic clear_wake = 1'b0;
    logic reg_wr = 1'b0;
    logic [4:0] reg_idx = 5'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic rd_chk = 1'b0;
    logic prev_wake = 1'b0;
    logic [7:0] prev_cnt = 8'h00;
    logic [7:0] exp_cnt = 8'h00;
    logic freq_detect;
    logic envelope;
    logic wake_q;
    logic [7:0] reg_rdata_q;
    logic [7:0] false_wakeup_count_q;
    int tick_cnt = 0;
    int mismatches = 0;
    int comparisons = 0;
    int seed = 11475;
    lfwc_note_t notes[$];

    lfwc_correlator #(.TOUT_STEP(TSTEP)) i_lfwc_correlator (.clock(clock), .reset_n(reset_n),
        .rtc_tick(rtc_tick), .freq_detect(freq_detect), .envelope(envelope), .clear_wake(clear_wake),
        .reg_wr(reg_wr), .reg_idx(reg_idx), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
        .false_wakeup_count_q(false_wakeup_count_q), .wake_q(wake_q));
    lfwc_tx_model i_lfwc_tx_model (.clock(clock), .rtc_tick(rtc_tick), .freq_detect(freq_detect),
        .envelope(envelope));

    // 50 MHz clock
    always #10 clock = ~clock;

    // Free-running RTC tick, one clock wide
    always @(posedge clock) begin
        tick_cnt <= (tick_cnt == TP - 1) ? 0 : tick_cnt + 1;
        rtc_tick <= (tick_cnt == TP - 1);
    end

    task automatic note(input logic [1:0] k, input logic [63:0] t, input logic [7:0] v);
        notes.push_back('{k, t, v});
    endtask : note

    // Kinds: 0 wake rise, 1 wake fall, 2 count change, 3 read; times get two clocks of slack
    task automatic check(input logic [1:0] k, input logic [63:0] t, input logic [7:0] v);
        lfwc_note_t n;
        comparisons++;
        if (notes.size() == 0) begin
            mismatches++;
            $display("ERROR %0t: unexpected event %0d value %h", $time, k, v);
            return;
        end
        n = notes.pop_front();
        if (n.kind !== k || n.v !== v || (k < 2'd2 && (t + 40 < n.t || t > n.t + 40))) begin
            mismatches++;
            $display("ERROR %0t: event %0d value %h, expected %0d value %h at %0d", $time, k, v, n.kind, n.v, n.t);
        end
    endtask : check

    // Watcher: every visible event takes the oldest note
    always @(negedge clock) begin
        if (reset_n) begin
            if (wake_q !== prev_wake) check(wake_q ? 2'd0 : 2'd1, $time - 10, 8'h00);
            if (false_wakeup_count_q !== prev_cnt) check(2'd2, 0, false_wakeup_count_q);
            if (rd_chk) check(2'd3, 0, reg_rdata_q);
        end
        prev_wake <= wake_q;
        prev_cnt <= false_wakeup_count_q;
    end

    // Extra edge at the end keeps back-to-back writes from toggling the strobe in one step
    task automatic wr(input logic [4:0] i, input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_idx <= i;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask : wr

    task automatic rd(input logic [4:0] i, input logic [7:0] exp);
        reg_idx <= i;
        note(2'd3, 0, exp);
        repeat (2) @(posedge clock);
        rd_chk <= 1'b1;
        @(posedge clock);
        rd_chk <= 1'b0;
    endtask : rd

    // Bounded wait until every noted event has shown up
    task automatic drain();
        for (int i = 0; i < 4000 && notes.size() != 0; i++) @(posedge clock);
    endtask : drain

    task automatic clear();
        note(2'd1, $time + 20, 8'h00);
        clear_wake <= 1'b1;
        @(posedge clock);
        clear_wake <= 1'b0;
        drain();
    endtask : clear

    // A good frame wakes two half bits after its last half; a bad one bumps the count
    task automatic frame(input logic [47:0] b, input int n, input logic [4:0] code, input logic tail, input bit ok);
        time t;
        int half;
        half = (code + 1) / 2;
        if (!ok) begin
            exp_cnt = exp_cnt + 8'h01;
            note(2'd2, 0, exp_cnt);
        end
        i_lfwc_tx_model.send(b, n, half, tail, t);
        if (ok) note(2'd0, t + 20 + 2 * half * TP * 20, 8'h00);
        drain();
        if (ok) clear();
    endtask : frame

    task automatic close_out();
        if (notes.size() != 0) mismatches++;
        if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : close_out

    // Main sequence
    initial begin
        logic [15:0] p;
        logic [7:0] s;
        logic [4:0] code;
        time t;
        logic [15:0] miss [4];
        logic [4:0] ridx [7];
        logic [7:0] rval [7];
        miss = '{16'h0000, 16'h8000, 16'h8200, 16'h8220};
        ridx = '{5'h01, 5'h02, 5'h05, 5'h06, 5'h07, 5'h0d, 5'h03};
        rval = '{8'h00, 8'h00, 8'h96, 8'h69, 8'h0b, 8'h00, 8'h00};
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        wr(5'h0d, 8'hff);
        for (int k = 0; k < 7; k++) rd(ridx[k], rval[k]);
        for (int c = 0; c < 8; c++) begin
            wr(5'h07, {c[2:0], 5'h0b});
            i_lfwc_tx_model.detect(t);
            note(2'd0, t + 20, 8'h00);
            if (c == 0) begin
                repeat (300) @(posedge clock);
                clear();
            end else begin
                note(2'd1, t + 20 + c * TSTEP * 20, 8'h00);
                drain();
            end
        end
        wr(5'h01, 8'h02);
        for (int k = 0; k < 3; k++) begin
            s = 8'($random(seed));
            code = (k == 0) ? 5'h03 : (k == 1) ? 5'h1f : 5'(3 + {$random(seed)} % 29);
            for (int j = 0; j < 8; j++) p[15 - 2 * j -: 2] = s[7 - j] ? 2'b10 : 2'b01;
            wr(5'h07, {3'h0, code});
            wr(5'h05, p[15:8]);
            wr(5'h06, p[7:0]);
            rd(5'h05, p[15:8]);
            frame({24'h0, 8'haa, p}, 24, code, 1'b0, 1'b1);
        end
        wr(5'h07, 8'h0b);
        wr(5'h05, 8'h96);
        wr(5'h06, 8'h69);
        for (int k = 0; k < 4; k++) begin
            wr(5'h02, {1'b0, k[1:0], 5'h00});
            frame({24'h0, 8'haa, 16'h9669 & ~miss[k]}, 24, 5'h0b, 1'b0, 1'b1);
            if (k < 3) frame({24'h0, 8'haa, 16'h9669 & ~miss[k + 1]}, 24, 5'h0b, 1'b1, 1'b0);
        end
        frame({24'h0, 8'haa, 16'hd669}, 24, 5'h0b, 1'b1, 1'b0);
        frame({26'h0, 6'h2a, 16'h9669}, 22, 5'h0b, 1'b1, 1'b0);
        frame(48'h0, 1, 5'h0b, 1'b0, 1'b0);
        wr(5'h01, 8'h06);
        frame({8'h0, 8'haa, 32'h96699669}, 40, 5'h0b, 1'b0, 1'b1);
        frame({8'h0, 8'haa, 32'h9669d669}, 40, 5'h0b, 1'b0, 1'b0);
        repeat (200) @(posedge clock);
        rd(5'h0d, exp_cnt);
        close_out();
    end

    // Hang guard, well above the expected run of some 20k cycles
    initial begin
        #2_000_000;
        mismatches++;
        close_out();
    end
endmodule : lfwc_correlator_bench
